/* File: bbfc_asserts.sv */
// Pin checks for the flash bus controller
`timescale 1ns/100ps
module bbfc_asserts (
	input wire logic                 mclk_i,               // Clock
	input wire logic                 rst_b_i,              // Reset, low active
	input wire bbfc_pkg::bbfc_ctrl_t pin_ctrl_o,           // Flash pins
	input wire logic [16:0]          word_address_lines_o, // Address
	input wire logic [15:0]          dq_o,                 // Data out
	input wire logic [15:0]          dq_oe_b_o             // Data enable
);
	wire ce = pin_ctrl_o.chip_en_b, oe = pin_ctrl_o.out_en_b, we = pin_ctrl_o.wr_en_b, rb = pin_ctrl_o.reset_b;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	property p_read; !oe |-> we && !ce && (&dq_oe_b_o[7:0]); endproperty
	a_read: assert property (p_read) else $error("Read overlaps write or drive");
	property p_upper; !pin_ctrl_o.word_mode |-> &dq_oe_b_o[14:8]; endproperty
	a_upper: assert property (p_upper) else $error("Upper lines driven in byte mode");
	property p_lowa; rb && !ce && !pin_ctrl_o.word_mode |-> !dq_oe_b_o[15]; endproperty
	a_lowa: assert property (p_lowa) else $error("Low address bit not driven");
	property p_cmd; !we |-> !ce && dq_oe_b_o[7:0] == 8'h00; endproperty
	a_cmd: assert property (p_cmd) else $error("Write without lower data");
	property p_hold; $rose(we) |-> $stable(word_address_lines_o) && $stable(dq_o); endproperty
	a_hold: assert property (p_hold) else $error("Address or data moved at write end");
	property p_rst; $fell(rb) |-> !rb[*8]; endproperty
	a_rst: assert property (p_rst) else $error("Flash reset too short");
	property p_unlk; pin_ctrl_o.unlock |-> rb; endproperty
	a_unlk: assert property (p_unlk) else $error("Unlock while reset low");
	property p_desel; ce |-> oe && we; endproperty
	a_desel: assert property (p_desel) else $error("Strobe while deselected");
endmodule // bbfc_asserts

/* File: bbfc_flash_model.sv */
// Behavioural flash device on the parallel bus
`timescale 1ns/100ps
module bbfc_flash_model #(
	parameter int WR_NS = 6000 // Write duration
) (
	input  wire bbfc_pkg::bbfc_ctrl_t c_i,  // Control pins
	input  wire logic [16:0]          a_i,  // Word address
	input  wire logic [15:0]          dq_i, // Data wire level
	output logic      [15:0]          dq_o  // Device drive
);
	logic [15:0] mem [0:131071]; // Array
	logic [15:0] rd, last, wd;   // Read value, old value, write data
	logic [16:0] wa;             // Write address
	logic [7:0]  st;             // Status byte
	logic        stm, arm;       // Status mode, write armed
	wire en = c_i.reset_b && !c_i.chip_en_b && !c_i.out_en_b;
	initial begin
		for (int i = 0; i < 131072; i++) mem[i] = 16'hffff;
		{last, st, stm, arm} = {16'h0, 8'h80, 2'b00};
	end
	// Output follows the address
	always_comb rd = stm ? {8'h0, st} : c_i.word_mode ? mem[a_i] : {8'h0, dq_i[15] ? mem[a_i][15:8] : mem[a_i][7:0]};
	always @(negedge en) last = rd;
	// Released lines show the inverse of the old value
	assign dq_o = en ? {c_i.word_mode ? rd[15:8] : ~last[15:8], rd[7:0]} : ~last;
	// Cycle taken on rising write enable
	always @(posedge c_i.wr_en_b or negedge c_i.reset_b) begin
		if (!c_i.reset_b) {st, stm, arm} = {8'h80, 2'b00};
		else if (c_i.chip_en_b) ;
		else if (arm && c_i.prog_high) begin
			{arm, stm} = 2'b01;
			if (a_i >= 17'h1e000 && !c_i.unlock) st[4] = 1;
			else if (!st[3]) {wa, wd, st[7]} = {a_i, dq_i, 1'b0};
		end else if (arm) {arm, st[3]} = 2'b01;
		else case (dq_i[7:0])
			8'h40: {arm, stm} = 2'b11;
			8'h70: stm = 1;
			8'h50: st[4:3] = 2'b00;
			8'hff: stm = 0;
			default: ;
		endcase
	end
	// Self-timed write
	always @(negedge st[7]) begin
		#WR_NS;
		mem[wa] = wd;
		st[7] = 1;
	end
endmodule // bbfc_flash_model

/* File: bbfc_params.svh */
// Constants for the boot block flash bus controller
`ifndef BBFC_PARAMS_SVH
`define BBFC_PARAMS_SVH
`define BBFC_CLK_NS        20
`define BBFC_ADDR_CTRL     4'h0
`define BBFC_ADDR_ADDR     4'h4
`define BBFC_ADDR_WDATA    4'h8
`define BBFC_ADDR_RDATA    4'hc
`define BBFC_CTRL_GO       0
`define BBFC_CTRL_WRITE    1
`define BBFC_CTRL_WORD     2
`define BBFC_CTRL_HIPROG   3
`define BBFC_CTRL_UNLOCK   4
`define BBFC_CTRL_RESET    5
`define BBFC_SETUP_NS      50
`define BBFC_SETUP_CYC     ((`BBFC_SETUP_NS + `BBFC_CLK_NS - 1) / `BBFC_CLK_NS)
`define BBFC_PULSE_NS      100
`define BBFC_PULSE_CYC     ((`BBFC_PULSE_NS + `BBFC_CLK_NS - 1) / `BBFC_CLK_NS)
`define BBFC_RECOV_NS      220
`define BBFC_RECOV_CYC     ((`BBFC_RECOV_NS + `BBFC_CLK_NS - 1) / `BBFC_CLK_NS)
`endif

/* File: bbfc_pkg.sv */
// Types for the boot block flash bus controller
package bbfc_pkg;
	typedef enum logic [2:0] {BBFC_IDLE, BBFC_SETUP, BBFC_PULSE, BBFC_HOLD, BBFC_DONE, BBFC_RST} bbfc_state_t;
	typedef struct packed {
		logic        chip_en_b;   // Chip enable, low active
		logic        out_en_b;    // Output enable, low active
		logic        wr_en_b;     // Write enable, low active
		logic        reset_b;     // Reset pin, low active
		logic        unlock;      // Raise reset pin to unlock voltage
		logic        prog_high;   // Program supply at high level
		logic        word_mode;   // Bus width select, high is 16-bit
	} bbfc_ctrl_t;
endpackage

/* File: bbfc_tb.sv */
// Self-checking bench for the flash bus controller
`timescale 1ns/100ps
module testbench;
	logic                 mclk_i = 0, rst_b_i = 0, avs_read_i = 0, avs_write_i = 0, avs_waitrequest_o; // Bus
	logic [3:0]           avs_address_i = 4'h0;                  // Register address
	logic [31:0]          avs_writedata_i = 32'h0, avs_readdata_o, q; // Bus data, last read
	bbfc_pkg::bbfc_ctrl_t pin_ctrl_o;                            // Flash pins
	logic [16:0]          word_address_lines_o;                  // Flash address
	logic [15:0]          dq_o, dq_oe_b_o, dq_i, fm_q;           // Data paths
	int                   errors = 0, n_compared = 0;            // Counts
	localparam logic [4:0] CW = 5'h03, CR = 5'h02, CP = 5'h07;   // Command, read, array write
	always #10 mclk_i = ~mclk_i;
	assign dq_i = (~dq_oe_b_o & dq_o) | (dq_oe_b_o & fm_q); // Wire level
	bbfc_top dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .pin_ctrl_o(pin_ctrl_o),
		.word_address_lines_o(word_address_lines_o), .dq_o(dq_o), .dq_oe_b_o(dq_oe_b_o), .dq_i(dq_i));
	bbfc_flash_model fm_u (.c_i(pin_ctrl_o), .a_i(word_address_lines_o), .dq_i(dq_i), .dq_o(fm_q));
	task end_sim;
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input logic [15:0] s, input logic [15:0] e);
		n_compared++;
		if (s !== e) begin
			errors++;
			$display("Error at %0t: saw %h, expected %h", $time, s, e);
		end
	endtask
	// One bus access, held until waitrequest is low
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		{avs_address_i, avs_writedata_i, avs_read_i, avs_write_i} <= {a, d, !w, w};
		do @(posedge mclk_i); while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		{avs_read_i, avs_write_i} <= 2'b00;
	endtask
	// One flash cycle, then fetch read data
	task op(input logic [4:0] c, input logic [17:0] a, input logic [15:0] d);
		bus(1, 4'h4, {14'h0, a});
		bus(1, 4'h8, {16'h0, d});
		bus(1, 4'h0, {26'h0, c, 1'b1});
		do bus(0, 4'h0, 0); while (q[6] !== 1'b0);
		bus(0, 4'hc, 0);
	endtask
	task poll(input logic [4:0] c);
		do op(c, 0, 0); while (q[7] !== 1'b1);
	endtask
	task t_refuse;
		bus(0, 4'h1, 0);
		chk(q[15:0], 16'h0000);
		$display("t_refuse done");
	endtask
	task t_write;
		op(CW, 0, 16'h0040);
		op(CP, 18'h00123, 16'h5aa5);
		op(CR, 0, 0);
		chk(q[15:0], 16'h0000);
		poll(CR);
		chk(q[15:0], 16'h0080);
		op(CW, 0, 16'h00ff);
		op(CR, 18'h00123, 0);
		chk(q[15:0], 16'h5aa5);
		op(CR, 18'h00124, 0);
		chk(q[15:0], 16'hffff);
		$display("t_write done");
	endtask
	task t_byte;
		op(5'h00, 18'h00247, 0);
		chk({8'h0, q[7:0]}, 16'h005a);
		op(5'h00, 18'h00246, 0);
		chk({8'h0, q[7:0]}, 16'h00a5);
		$display("t_byte done");
	endtask
	task t_err;
		op(CW, 0, 16'h0040);
		op(CW, 18'h00200, 16'h1234);
		op(CR, 0, 0);
		chk(q[15:0], 16'h0088);
		op(CW, 0, 16'h0040);
		op(CP, 18'h00200, 16'h1234);
		op(CW, 0, 16'h0050);
		op(CR, 0, 0);
		chk(q[15:0], 16'h0080);
		op(CW, 0, 16'h00ff);
		op(CR, 18'h00200, 0);
		chk(q[15:0], 16'hffff);
		$display("t_err done");
	endtask
	task t_boot;
		op(CW, 0, 16'h0040);
		op(CP, 18'h1e000, 16'hbeef);
		op(CR, 0, 0);
		chk(q[15:0], 16'h0090);
		op(CW, 0, 16'h0050);
		op(CW, 0, 16'h0040);
		op(5'h0f, 18'h1e000, 16'hbeef);
		poll(5'h0a);
		chk(q[15:0], 16'h0080);
		op(CW, 0, 16'h00ff);
		op(CR, 18'h1e000, 0);
		chk(q[15:0], 16'hbeef);
		$display("t_boot done");
	endtask
	task t_reset;
		op(CW, 0, 16'h0070);
		op(5'h10, 0, 0);
		op(CR, 18'h00123, 0);
		chk(q[15:0], 16'h5aa5);
		$display("t_reset done");
	endtask
	initial begin
		repeat (8) @(posedge mclk_i);
		rst_b_i <= 1;
		t_refuse;
		t_write;
		t_byte;
		t_err;
		t_boot;
		t_reset;
		end_sim;
	end
	initial begin
		#1000000;
		errors++;
		end_sim;
	end
endmodule // testbench
bind bbfc_top bbfc_asserts chk_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .pin_ctrl_o(pin_ctrl_o),
	.word_address_lines_o(word_address_lines_o), .dq_o(dq_o), .dq_oe_b_o(dq_oe_b_o));

/* File: bbfc_top.sv */
// Host controller driving the boot block flash parallel bus
`timescale 1ns/100ps
`include "bbfc_params.svh"
module bbfc_top (
	input  wire logic        mclk_i,        // 50 MHz clock
	input  wire logic        rst_b_i,       // Async reset, low active
	input  wire logic [3:0]  avs_address_i, // Byte address
	input  wire logic        avs_read_i,    // Read request
	input  wire logic        avs_write_i,   // Write request
	input  wire logic [31:0] avs_writedata_i, // Write data
	output logic      [31:0] avs_readdata_o,  // Read data
	output logic             avs_waitrequest_o, // Stall
	output bbfc_pkg::bbfc_ctrl_t pin_ctrl_o,  // Flash control pins
	output logic      [16:0] word_address_lines_o, // Word address
	output logic      [15:0] dq_o,          // Data out
	output logic      [15:0] dq_oe_b_o,     // Data enable, low drives
	input  wire logic [15:0] dq_i           // Data in from pins
);
	// Five bits so that pulse plus recovery still fits without wrapping
	localparam logic [4:0] SETUP_CYC = 5'(`BBFC_SETUP_CYC);
	localparam logic [4:0] PULSE_CYC = 5'(`BBFC_PULSE_CYC);
	localparam logic [4:0] RECOV_CYC = 5'(`BBFC_RECOV_CYC);

	bbfc_pkg::bbfc_state_t state, next_state;   // Cycle sequencer
	logic [4:0]  cnt, next_cnt;                 // Phase timer
	logic [5:0]  ctrl, next_ctrl;               // Control register
	logic [17:0] addr, next_addr;               // Byte address in byte mode, bit 0 high selects the upper byte; word address in word mode
	logic [15:0] wdata, next_wdata;             // Write data
	logic [15:0] rdata, next_rdata;             // Captured read data
	logic        busy, next_busy;               // Cycle in progress
	logic [31:0] next_readdata;                 // Bus read data
	logic        next_wait;                     // Bus stall
	bbfc_pkg::bbfc_ctrl_t next_pins;            // Pin controls
	logic [16:0] next_wa;                       // Word address
	logic [15:0] next_dq, next_oe_b;            // Data drive
	logic [15:0] dq_s1, dq_s2;                  // Data synchroniser

	// Data pins cross from outside into the clock domain
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dq_s1 <= 16'h0000;
			dq_s2 <= 16'h0000;
		end else begin
			dq_s1 <= dq_i;
			dq_s2 <= dq_s1;
		end
	end

	// Bus slave and cycle sequencer next values
	always_comb begin
		next_state    = state;
		next_cnt      = cnt;
		next_ctrl     = ctrl;
		next_addr     = addr;
		next_wdata    = wdata;
		next_rdata    = rdata;
		next_busy     = busy;
		next_readdata = avs_readdata_o;
		next_wait     = 1'b1;
		// Bus access answered one cycle after request; control write stalled while busy
		if ((avs_read_i || avs_write_i) && avs_waitrequest_o && !(avs_address_i == `BBFC_ADDR_CTRL
			&& avs_write_i && busy)) begin
			next_wait = 1'b0;
			if (avs_write_i) begin
				unique case (avs_address_i)
					`BBFC_ADDR_CTRL: begin
						next_ctrl = avs_writedata_i[5:0];
						if (avs_writedata_i[`BBFC_CTRL_GO] || avs_writedata_i[`BBFC_CTRL_RESET])
							next_busy = 1'b1;
					end
					`BBFC_ADDR_ADDR:  next_addr  = avs_writedata_i[17:0];
					`BBFC_ADDR_WDATA: next_wdata = avs_writedata_i[15:0];
					default:          next_busy  = busy;   // Unmapped write ignored
				endcase
			end else begin
				unique case (avs_address_i)
					`BBFC_ADDR_CTRL:  next_readdata = {25'h0, busy, ctrl[5:1], 1'b0};
					`BBFC_ADDR_ADDR:  next_readdata = {14'h0, addr};
					`BBFC_ADDR_WDATA: next_readdata = {16'h0, wdata};
					`BBFC_ADDR_RDATA: next_readdata = {16'h0, rdata};
					default:          next_readdata = 32'h0;
				endcase
			end
		end
		// Flash cycle sequencer
		unique case (state)
			bbfc_pkg::BBFC_IDLE: begin
				next_cnt = 5'h00;
				if (busy && ctrl[`BBFC_CTRL_RESET]) next_state = bbfc_pkg::BBFC_RST;
				else if (busy) next_state = bbfc_pkg::BBFC_SETUP;
			end
			bbfc_pkg::BBFC_RST: begin
				next_cnt = cnt + 5'h01;
				if (cnt == 5'(PULSE_CYC + RECOV_CYC)) next_state = bbfc_pkg::BBFC_DONE;
			end
			bbfc_pkg::BBFC_SETUP: begin              // Address and data settle
				next_cnt = cnt + 5'h01;
				if (cnt == SETUP_CYC) begin
					next_cnt   = 5'h00;
					next_state = bbfc_pkg::BBFC_PULSE;
				end
			end
			bbfc_pkg::BBFC_PULSE: begin              // Strobe low
				next_cnt = cnt + 5'h01;
				if (cnt == PULSE_CYC) begin
					next_cnt   = 5'h00;
					next_state = bbfc_pkg::BBFC_HOLD;
					if (!ctrl[`BBFC_CTRL_WRITE]) begin
						if (ctrl[`BBFC_CTRL_WORD]) next_rdata = dq_s2;
						else next_rdata = {8'h00, dq_s2[7:0]};
					end
				end
			end
			bbfc_pkg::BBFC_HOLD: begin               // hold after rising strobe
				next_cnt = cnt + 5'h01;
				if (cnt == SETUP_CYC) next_state = bbfc_pkg::BBFC_DONE;
			end
			bbfc_pkg::BBFC_DONE: begin
				next_busy  = 1'b0;
				next_ctrl  = {1'b0, ctrl[4:1], 1'b0};
				next_state = bbfc_pkg::BBFC_IDLE;
			end
			default: next_state = bbfc_pkg::BBFC_IDLE;
		endcase
	end

	// Pin drive next values
	always_comb begin
		next_pins.reset_b   = (state != bbfc_pkg::BBFC_RST);
		next_pins.unlock    = ctrl[`BBFC_CTRL_UNLOCK];
		next_pins.prog_high = ctrl[`BBFC_CTRL_HIPROG];
		next_pins.word_mode = ctrl[`BBFC_CTRL_WORD];
		next_pins.chip_en_b = !(state == bbfc_pkg::BBFC_SETUP || state == bbfc_pkg::BBFC_PULSE
			|| state == bbfc_pkg::BBFC_HOLD);
		next_pins.out_en_b  = !(state == bbfc_pkg::BBFC_PULSE && !ctrl[`BBFC_CTRL_WRITE]);
		next_pins.wr_en_b   = !(state == bbfc_pkg::BBFC_PULSE && ctrl[`BBFC_CTRL_WRITE]);
		next_wa   = ctrl[`BBFC_CTRL_WORD] ? addr[16:0] : addr[17:1];
		next_dq   = wdata;
		next_oe_b = 16'hffff;
		if (!ctrl[`BBFC_CTRL_WORD]) begin
			next_dq[15] = addr[0];
			next_oe_b[15] = 1'b0;
		end
		if (ctrl[`BBFC_CTRL_WRITE] && !next_pins.chip_en_b) begin
			next_oe_b[7:0] = 8'h00;
			if (ctrl[`BBFC_CTRL_WORD]) next_oe_b[15:8] = 8'h00;
			else next_oe_b[14:8] = 7'h7f;
		end
	end

	// Register all state
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state     <= bbfc_pkg::BBFC_IDLE;
			cnt       <= 5'h00;
			ctrl      <= 6'h00;
			addr      <= 18'h00000;
			wdata     <= 16'h0000;
			rdata     <= 16'h0000;
			busy      <= 1'b0;
			avs_readdata_o    <= 32'h0;
			avs_waitrequest_o <= 1'b1;
			pin_ctrl_o        <= '{chip_en_b: 1'b1, out_en_b: 1'b1, wr_en_b: 1'b1, reset_b: 1'b0,
				unlock: 1'b0, prog_high: 1'b0, word_mode: 1'b0};
			word_address_lines_o <= 17'h00000;
			dq_o      <= 16'h0000;
			dq_oe_b_o <= 16'hffff;
		end else begin
			state     <= next_state;
			cnt       <= next_cnt;
			ctrl      <= next_ctrl;
			addr      <= next_addr;
			wdata     <= next_wdata;
			rdata     <= next_rdata;
			busy      <= next_busy;
			avs_readdata_o    <= next_readdata;
			avs_waitrequest_o <= next_wait;
			pin_ctrl_o        <= next_pins;
			word_address_lines_o <= next_wa;
			dq_o      <= next_dq;
			dq_oe_b_o <= next_oe_b;
		end
	end
endmodule // bbfc_top
